//--- lsta_cfg.svh
`ifndef LSTA_CFG_SVH
`define LSTA_CFG_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define LSTA_CLK_PERIOD_NS  20
`define LSTA_EVT_PULSE_NS   1000
`define LSTA_EVT_PULSE_CYC  ((`LSTA_EVT_PULSE_NS + `LSTA_CLK_PERIOD_NS - 1) / `LSTA_CLK_PERIOD_NS)
`define LSTA_RANGE_RST_US   500
`define LSTA_RANGE_RST_CYC  ((`LSTA_RANGE_RST_US * 1000) / `LSTA_CLK_PERIOD_NS)

// ==========================================================================
// Offsets and field values
// ==========================================================================
`define LSTA_FLAG_REG_OFS   8'h0c
`define LSTA_CH_LAST        2'h3
`define LSTA_CODE_PAD       5'h08
`define LSTA_CFG_FAULT      2'h0
`define LSTA_CFG_EACH_CH    2'h1
`define LSTA_CFG_ALL_CH     2'h3
`define LSTA_LATCH_TRANSP   1'b0
`define LSTA_LATCH_WINDOW   1'b1

`endif

//--- lsta_pkg.sv
package lsta_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE  = 4'b0001,
		ST_RRST  = 4'b0010,
		ST_START = 4'b0100,
		ST_WAIT  = 4'b1000
	} lsta_state_e;

	typedef enum logic [1:0]
	{
		MODE_OFF      = 2'h0,
		MODE_OS_FORCE = 2'h1,
		MODE_OS_REG   = 2'h2,
		MODE_CONT     = 2'h3
	} lsta_mode_e;

	typedef logic [35:0] lsta_code_t;

	typedef struct packed
	{
		lsta_state_e state;
		logic [1:0]  ch;
		logic [15:0] wait_cnt;
		logic [5:0]  pulse_cnt;
		logic [3:0]  hi_cnt;
		logic [3:0]  lo_cnt;
		logic        flag_h;
		logic        flag_l;
		logic        fault_act;
		logic        os_req;
		logic        os_by_req;
		logic        conv_start;
		logic        range_rst;
		logic        pwr_on;
		logic        evt_oe;
		logic        trig_s1;
		logic        trig_s2;
		logic        trig_s3;
	} lsta_core_s;

	typedef struct packed
	{
		logic rst_s1;
		logic rst_s2;
		logic dir_s1;
		logic dir_s2;
		logic pol_s1;
		logic pol_s2;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic trig_tgl;
	} lsta_link_s;

endpackage : lsta_pkg

//--- lsta_trigger_alert.sv
`timescale 1ns/100ps
`default_nettype none
`include "lsta_cfg.svh"

// What this block does
// - Pin edge, pin as input, starts one-shot
// - Trigger-input pin gives no completion indication
// - Request write starts; cleared on completion
// - Output pin signals completion for register starts
// - Standby after each one-shot; host allows recovery
// - Quick wake keeps analog powered between triggers
// - Regular one-shot paced only by triggers
// - Compare only the selected channel
// - Event pin open-drain: pull low or release
// - Pin active level follows polarity setting
// - Hold select: 0 transparent, 1 latched
// - Transparent: pin active above, inactive below
// - Transparent upper flag set above, cleared below
// - Transparent lower flag set below, cleared above
// - Latched: pin active until flag read
// - Latched flags set, cleared by flag read
// - Changes need consecutive fault count
// - Function 0 faults, 1 and 3 completion, 2 neither
// - Function 1: 1 us pulse per channel
// - Function 3: 1 us pulse per four
// - Flags keep threshold behaviour in completion mode
// - Continuous mode converts channels round-robin
// - One-shot converts all four channels once
// - Forced auto-range waits range reset time
module lsta_trigger_alert
	import lsta_pkg::*;
#(
	parameter int CODE_W        = 26,
	parameter int RANGE_RST_CYC = `LSTA_RANGE_RST_CYC
)
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic              ce_i,
	input  wire logic              link_clk_i,
	input  wire logic [1:0]        op_mode_i,
	input  wire logic              quick_wake_i,
	input  wire logic              event_dir_i,
	input  wire logic              event_pin_polarity_i,
	input  wire logic [1:0]        event_pin_func_i,
	input  wire logic              hold_select_i,
	input  wire logic [1:0]        fault_count_i,
	input  wire logic [1:0]        threshold_channel_select_i,
	input  wire logic [11:0]       thr_hi_result_i,
	input  wire logic [3:0]        thr_hi_exp_i,
	input  wire logic [11:0]       thr_lo_result_i,
	input  wire logic [3:0]        thr_lo_exp_i,
	input  wire logic              os_wr_i,
	input  wire logic              os_wdata_i,
	input  wire logic              flag_rd_i,
	input  wire logic              conv_done_i,
	input  wire logic [CODE_W-1:0] conv_code_i,
	input  wire logic              evt_pin_i,
	output logic                   evt_pin_o,
	output logic                   evt_pin_oe_o,
	output logic                   conv_start_o,
	output logic [1:0]             conv_ch_o,
	output logic                   range_reset_o,
	output logic                   analog_on_o,
	output logic                   busy_o,
	output logic                   os_req_o,
	output logic                   flag_h_o,
	output logic                   flag_l_o
);

	// ======================================================================
	// Elaboration checks
	// ======================================================================
	// Refused at elaboration, before any logic is built
	if (CODE_W < 1 || CODE_W > 36)
	begin : g_chk_code_w
		$error("CODE_W must lie in 1..36");
	end
	if (RANGE_RST_CYC < 1 || RANGE_RST_CYC > 65536)
	begin : g_chk_rrst
		$error("RANGE_RST_CYC must lie in 1..65536");
	end
	if (`LSTA_EVT_PULSE_CYC < 1 || `LSTA_EVT_PULSE_CYC > 63)
	begin : g_chk_pulse
		$error("Event pulse count does not fit its counter");
	end
	// Widest limit must still fit the comparison scale
	if (12 + `LSTA_CODE_PAD + 15 > $bits(lsta_code_t))
	begin : g_chk_thr_w
		$error("Threshold scale does not fit the code type");
	end

	localparam logic [15:0] RRST_LOAD = 16'(RANGE_RST_CYC - 1);
	localparam logic [5:0]  PULSE_LD  = 6'(`LSTA_EVT_PULSE_CYC);

	// ======================================================================
	// Functions
	// ======================================================================
	// Threshold field widened to the linear code scale
	function automatic lsta_code_t lsta_thr_code(input logic [11:0] res,
		input logic [3:0] ex);
		lsta_code_t v;
		v = {24'h000000, res};
		return v << (`LSTA_CODE_PAD + {1'b0, ex});
	endfunction : lsta_thr_code

	// Consecutive count step, saturating at the needed count
	function automatic logic [3:0] lsta_cnt_step(input logic [3:0] cnt,
		input logic [3:0] need);
		return (cnt >= need) ? need : cnt + 4'h1;
	endfunction : lsta_cnt_step

	// ======================================================================
	// Link domain: pin sampling and trigger edge
	// ======================================================================
	// A toggle crosses rather than a pulse: no width to lose in the crossing
	lsta_link_s lr;
	lsta_link_s lnxt;

	always_comb
	begin
		lnxt        = lr;
		lnxt.rst_s1 = nrst_i;
		lnxt.rst_s2 = lr.rst_s1;
		if (!lr.rst_s2)
		begin
			lnxt.dir_s1   = 1'b0;
			lnxt.dir_s2   = 1'b0;
			lnxt.pol_s1   = 1'b0;
			lnxt.pol_s2   = 1'b0;
			// Idle level of the pulled-up line, so release shows no edge
			lnxt.pin_s1   = 1'b1;
			lnxt.pin_s2   = 1'b1;
			lnxt.pin_prev = 1'b1;
			lnxt.trig_tgl = 1'b0;
		end
		else
		begin
			lnxt.dir_s1   = event_dir_i;
			lnxt.dir_s2   = lr.dir_s1;
			lnxt.pol_s1   = event_pin_polarity_i;
			lnxt.pol_s2   = lr.pol_s1;
			lnxt.pin_s1   = evt_pin_i;
			lnxt.pin_s2   = lr.pin_s1;
			lnxt.pin_prev = lr.pin_s2;
			// Edge into the active level, only while the pin is an input
			if (lr.dir_s2 && lr.pin_s2 == lr.pol_s2 && lr.pin_prev != lr.pol_s2)
				lnxt.trig_tgl = ~lr.trig_tgl;
		end
	end

	// Link logic runs free of ce_i; only the core freezes
	always_ff @(posedge link_clk_i)
	begin
		lr <= lnxt;
	end

	// ======================================================================
	// Core domain state
	// ======================================================================
	localparam lsta_core_s CORE_RST = '{state: ST_IDLE, default: '0};

	lsta_core_s r;
	lsta_core_s nxt;

	lsta_mode_e mode;
	logic       one_shot;
	logic       pin_trig;
	logic       req_trig;
	logic       last_ch;
	logic       hi_fault;
	logic       lo_fault;
	logic       hi_conf;
	logic       lo_conf;
	logic       evt_act;
	logic       evt_level;
	logic [3:0] need;
	logic [3:0] hc;
	logic [3:0] lc;
	lsta_code_t code;

	always_comb
	begin
		nxt            = r;
		nxt.conv_start = 1'b0;
		nxt.range_rst  = 1'b0;
		mode           = lsta_mode_e'(op_mode_i);
		one_shot       = (mode == MODE_OS_FORCE) || (mode == MODE_OS_REG);
		code           = lsta_code_t'(conv_code_i);
		need           = 4'h1 << fault_count_i;
		hc             = lsta_cnt_step(r.hi_cnt, need);
		lc             = lsta_cnt_step(r.lo_cnt, need);
		hi_fault       = code > lsta_thr_code(thr_hi_result_i, thr_hi_exp_i);
		lo_fault       = code < lsta_thr_code(thr_lo_result_i, thr_lo_exp_i);
		hi_conf        = hi_fault && (hc >= need);
		lo_conf        = lo_fault && (lc >= need);
		last_ch        = (r.ch == `LSTA_CH_LAST) && (mode != MODE_CONT);

		// Trigger toggle crossing; only the second and third stages are compared
		nxt.trig_s1 = lr.trig_tgl;
		nxt.trig_s2 = r.trig_s1;
		nxt.trig_s3 = r.trig_s2;
		pin_trig    = (r.trig_s2 ^ r.trig_s3) && event_dir_i;
		req_trig    = r.os_req;

		// Flag read clears first, so a fault in the same cycle still sets
		if (flag_rd_i && hold_select_i == `LSTA_LATCH_WINDOW)
		begin
			nxt.flag_h    = 1'b0;
			nxt.flag_l    = 1'b0;
			nxt.fault_act = 1'b0;
		end

		if (os_wr_i)
			nxt.os_req = os_wdata_i;

		if (r.pulse_cnt != 6'h00)
			nxt.pulse_cnt = r.pulse_cnt - 6'h01;

		// ==================================================================
		// Measurement sequencer
		// ==================================================================
		case (r.state)
			ST_IDLE:
			begin
				nxt.ch = 2'h0;
				if (mode == MODE_CONT)
					nxt.state = ST_START;
				else if (one_shot && (pin_trig || req_trig))
				begin
					// A pending request is used up even when the pin fires too
					nxt.os_by_req = req_trig;
					if (mode == MODE_OS_FORCE)
					begin
						nxt.range_rst = 1'b1;
						nxt.wait_cnt  = RRST_LOAD;
						nxt.state     = ST_RRST;
					end
					else
						nxt.state = ST_START;
				end
			end
			ST_RRST:
			begin
				// Range logic recovers while no conversion may start
				if (r.wait_cnt == 16'h0000)
					nxt.state = ST_START;
				else
					nxt.wait_cnt = r.wait_cnt - 16'h0001;
			end
			ST_START:
			begin
				nxt.conv_start = 1'b1;
				nxt.state      = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (conv_done_i)
				begin
					// Threshold logic on the selected channel only
					if (r.ch == threshold_channel_select_i)
					begin
						if (hi_fault)
						begin
							nxt.hi_cnt = hc;
							nxt.lo_cnt = 4'h0;
						end
						else if (lo_fault)
						begin
							nxt.lo_cnt = lc;
							nxt.hi_cnt = 4'h0;
						end
						else
						begin
							nxt.hi_cnt = 4'h0;
							nxt.lo_cnt = 4'h0;
						end
						if (hold_select_i == `LSTA_LATCH_TRANSP)
						begin
							if (hi_conf)
							begin
								nxt.flag_h    = 1'b1;
								nxt.flag_l    = 1'b0;
								nxt.fault_act = 1'b1;
							end
							else if (lo_conf)
							begin
								nxt.flag_h    = 1'b0;
								nxt.flag_l    = 1'b1;
								nxt.fault_act = 1'b0;
							end
						end
						else
						begin
							if (hi_conf)
								nxt.flag_h = 1'b1;
							if (lo_conf)
								nxt.flag_l = 1'b1;
							if (hi_conf || lo_conf)
								nxt.fault_act = 1'b1;
						end
					end
					// Completion pulses
					if (event_pin_func_i == `LSTA_CFG_EACH_CH)
						nxt.pulse_cnt = PULSE_LD;
					else if (event_pin_func_i == `LSTA_CFG_ALL_CH &&
						r.ch == `LSTA_CH_LAST)
						nxt.pulse_cnt = PULSE_LD;
					if (last_ch)
					begin
						nxt.state = ST_IDLE;
						// A write in this cycle wins over the automatic clear
						if (r.os_by_req && !os_wr_i)
							nxt.os_req = 1'b0;
						nxt.os_by_req = 1'b0;
					end
					else
					begin
						nxt.ch    = r.ch + 2'h1;
						nxt.state = ST_START;
					end
				end
			end
			default:
			begin
				nxt.state = ST_IDLE;
			end
		endcase

		// Analog power: off in standby unless quick wake holds it up
		nxt.pwr_on = (nxt.state != ST_IDLE) || (mode == MODE_CONT) ||
			(quick_wake_i && one_shot);

		// ==================================================================
		// Event pin drive
		// ==================================================================
		// Any nonzero function drops faults; only 1 and 3 load completion pulses
		if (event_pin_func_i == `LSTA_CFG_FAULT)
			evt_act = nxt.fault_act;
		else
			evt_act = (nxt.pulse_cnt != 6'h00);
		evt_level = evt_act ? event_pin_polarity_i : ~event_pin_polarity_i;
		// Only ever pulls low; no drive while the pin is a trigger input
		nxt.evt_oe = !event_dir_i && !evt_level;
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			r <= CORE_RST;
		else if (ce_i)
			r <= nxt;
	end

	// ======================================================================
	// Outputs
	// ======================================================================
	// Line moves by the enable alone; never driven high
	assign evt_pin_o     = 1'b0;
	assign evt_pin_oe_o  = r.evt_oe;
	assign conv_start_o  = r.conv_start;
	assign conv_ch_o     = r.ch;
	assign range_reset_o = r.range_rst;
	assign analog_on_o   = r.pwr_on;
	assign busy_o        = (r.state != ST_IDLE);
	assign os_req_o      = r.os_req;
	assign flag_h_o      = r.flag_h;
	assign flag_l_o      = r.flag_l;

endmodule : lsta_trigger_alert

`default_nettype wire

//--- lsta_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// Converter on the far side of the block
module lsta_conv_model
(
	input  wire logic        clk_i,
	input  wire logic        start_i,
	input  wire logic [1:0]  ch_i,
	input  wire logic [7:0]  lat_i,
	input  wire logic [25:0] level_i,
	output logic             done_o,
	output logic [25:0]      code_o
);
	logic [7:0] cnt_r;
	logic       run_r;

	initial
	begin
		run_r = 1'b0;
		cnt_r = 8'h0;
		done_o = 1'b0;
		code_o = 26'h0;
	end

	// Code toggles while invalid so no stale value looks real
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		code_o <= ~code_o;
		if (start_i)
		begin
			cnt_r <= lat_i;
			run_r <= 1'b1;
		end
		else if (run_r && cnt_r == 8'h0)
		begin
			run_r  <= 1'b0;
			done_o <= 1'b1;
			code_o <= (ch_i == 2'h2) ? level_i : 26'h0;
		end
		else if (run_r)
			cnt_r <= cnt_r - 8'h1;
	end
endmodule : lsta_conv_model
`default_nettype wire

//--- lsta_trigger_alert_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// Port checker
module lsta_chk
	import lsta_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic [1:0] op_mode_i,
	input wire logic       quick_wake_i,
	input wire logic       event_dir_i,
	input wire logic       event_pin_polarity_i,
	input wire logic [1:0] event_pin_func_i,
	input wire logic       hold_select_i,
	input wire logic       os_wr_i,
	input wire logic       os_wdata_i,
	input wire logic       flag_rd_i,
	input wire logic       conv_done_i,
	input wire logic       evt_pin_o,
	input wire logic       evt_pin_oe_o,
	input wire logic       conv_start_o,
	input wire logic [1:0] conv_ch_o,
	input wire logic       range_reset_o,
	input wire logic       analog_on_o,
	input wire logic       busy_o,
	input wire logic       os_req_o,
	input wire logic       flag_h_o,
	input wire logic       flag_l_o
);
	logic [7:0] run_r;

	always_ff @(posedge clk_i)
		run_r <= (!nrst_i || !evt_pin_oe_o) ? 8'h0 : run_r + 8'h1;

	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_req_start;
		os_req_o ##1 busy_o ##1 (conv_start_o && conv_ch_o == 2'h0);
	endsequence
	sequence s_next_ch;
		##2 (conv_start_o && conv_ch_o == $past(conv_ch_o, 2) + 2'h1);
	endsequence

	AST_OPEN_DRAIN: assert property (!evt_pin_o)
		else $error("event pin driven high");
	AST_DIR_IN: assert property (event_dir_i && $past(event_dir_i) |-> !evt_pin_oe_o)
		else $error("pin pulled while input");
	AST_REQ_START: assert property (os_wr_i && os_wdata_i && !busy_o && !os_req_o
		&& op_mode_i == 2'h2 |=> s_req_start)
		else $error("request did not start");
	AST_NEXT_CH: assert property (conv_done_i && busy_o && conv_ch_o != 2'h3 |-> s_next_ch)
		else $error("next channel wrong");
	AST_STANDBY: assert property ($fell(busy_o) && !quick_wake_i && op_mode_i != 2'h3
		|-> ##[0:1] !analog_on_o)
		else $error("no standby");
	AST_NO_REPEAT: assert property (!busy_o && !os_req_o && !os_wr_i && !event_dir_i
		&& !$past(event_dir_i) && op_mode_i == 2'h2 |=> !busy_o)
		else $error("start without trigger");
	AST_RANGE_WAIT: assert property (range_reset_o |=> !conv_start_o [*8])
		else $error("range reset skipped");
	AST_PULSE: assert property ($fell(evt_pin_oe_o) && event_pin_func_i == 2'h1
		&& !event_pin_polarity_i && !event_dir_i |-> run_r == 8'h32)
		else $error("pulse width wrong");
	AST_LATCH_CLR: assert property (flag_rd_i && hold_select_i && !conv_done_i
		|=> !flag_h_o && !flag_l_o)
		else $error("flags not cleared");
endmodule : lsta_chk

bind lsta_trigger_alert lsta_chk u_chk (.clk_i, .nrst_i, .op_mode_i, .quick_wake_i,
	.event_dir_i, .event_pin_polarity_i, .event_pin_func_i, .hold_select_i, .os_wr_i,
	.os_wdata_i, .flag_rd_i, .conv_done_i, .evt_pin_o, .evt_pin_oe_o, .conv_start_o,
	.conv_ch_o, .range_reset_o, .analog_on_o, .busy_o, .os_req_o, .flag_h_o, .flag_l_o);
`default_nettype wire

//--- test_light_sensor_trigger_and_alert.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================
// Bench
module test_light_sensor_trigger_and_alert;
	import lsta_pkg::*;
	logic        clk, lclk, nrst, qw, dir, pol, hold, os_wr, os_wd, frd, pin_drv, ce;
	logic        oe, oe_q, evt_o, cst, done, busy, osr, fh, fl, rr, aon;
	logic [1:0]  mode, func, fcnt, sel, ch;
	logic [7:0]  lat;
	logic [25:0] level, code;
	int          n_fail, n_compared, n_st, n_rise, n_rr, cyc;
	wire         evt_pin = oe ? 1'b0 : pin_drv;

	lsta_trigger_alert #(.RANGE_RST_CYC(20)) DUT (.clk_i(clk), .nrst_i(nrst), .ce_i(ce),
		.link_clk_i(lclk), .op_mode_i(mode), .quick_wake_i(qw), .event_dir_i(dir),
		.event_pin_polarity_i(pol), .event_pin_func_i(func), .hold_select_i(hold),
		.fault_count_i(fcnt), .threshold_channel_select_i(sel), .thr_hi_result_i(12'h010),
		.thr_hi_exp_i(4'h0), .thr_lo_result_i(12'h004), .thr_lo_exp_i(4'h0), .os_wr_i(os_wr),
		.os_wdata_i(os_wd), .flag_rd_i(frd), .conv_done_i(done), .conv_code_i(code),
		.evt_pin_i(evt_pin), .evt_pin_o(evt_o), .evt_pin_oe_o(oe), .conv_start_o(cst),
		.conv_ch_o(ch), .range_reset_o(rr), .analog_on_o(aon), .busy_o(busy),
		.os_req_o(osr), .flag_h_o(fh), .flag_l_o(fl));

	lsta_conv_model u_conv (.clk_i(clk), .start_i(cst), .ch_i(ch), .lat_i(lat),
		.level_i(level), .done_o(done), .code_o(code));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		lclk = 1'b0;
		#37;
		forever #62.5 lclk = ~lclk;
	end

	// Counted mid-cycle, where the outputs have settled
	always @(negedge clk)
	begin
		cyc++;
		oe_q <= oe;
		if (cst)
			n_st++;
		if (rr)
			n_rr++;
		if (oe && !oe_q)
			n_rise++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask : chk

	task automatic end_of_test();
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic shot();
		@(posedge clk);
		os_wr <= 1'b1;
		@(posedge clk);
		os_wr <= 1'b0;
		#1 chk(osr, 32'h1);
		do
		begin
			@(posedge clk);
			#1;
		end
		while (busy);
		chk(osr, 32'h0);
	endtask : shot

	task automatic meas(input logic [25:0] lv, input logic [2:0] e);
		level <= lv;
		shot();
		@(posedge clk);
		#1 chk({fh, fl, oe}, e);
	endtask : meas

	task automatic rd();
		@(posedge clk);
		frd <= 1'b1;
		@(posedge clk);
		frd <= 1'b0;
		@(posedge clk);
		#1 chk({fh, fl, oe}, 3'b000);
	endtask : rd

	// Pol low: an active pin shows as pull-down
	task automatic t_thr();
		logic [25:0] lv [4] = '{26'h2000, 26'h800, 26'h100, 26'h800};
		logic [2:0]  ex [4] = '{3'b101, 3'b101, 3'b010, 3'b010};
		for (int i = 0; i < 4; i++)
			meas(lv[i], ex[i]);
		sel <= 2'h0;
		meas(26'h2000, 3'b010);
		sel <= 2'h2;
		hold <= 1'b1;
		rd();
		meas(26'h2000, 3'b101);
		meas(26'h800, 3'b101);
		rd();
		fcnt <= 2'h1;
		meas(26'h100, 3'b000);
		meas(26'h100, 3'b011);
		rd();
		fcnt <= 2'h0;
		hold <= 1'b0;
	endtask : t_thr

	// Slow converter keeps per-channel pulses apart
	task automatic t_reg(input logic [1:0] f, input int n);
		func <= f;
		lat <= 8'h50;
		n_rise = 0;
		n_st = 0;
		shot();
		repeat (60) @(posedge clk);
		chk(n_st, 32'h4);
		chk(n_rise, n);
		chk({fh, fl}, 2'b01);
		chk(aon, 32'h0);
	endtask : t_reg

	task automatic t_pin();
		dir <= 1'b1;
		pol <= 1'b1;
		pin_drv <= 1'b0;
		repeat (20) @(posedge clk);
		n_st = 0;
		n_rise = 0;
		pin_drv <= 1'b1;
		repeat (40) @(posedge clk);
		#1 chk(busy, 32'h1);
		while (busy)
		begin
			@(posedge clk);
			#1;
		end
		chk(n_st, 32'h4);
		chk(n_rise, 32'h0);
		dir <= 1'b0;
		pol <= 1'b0;
	endtask : t_pin

	task automatic t_force();
		mode <= 2'h1;
		qw <= 1'b1;
		lat <= 8'h3;
		n_rr = 0;
		shot();
		chk(n_rr, 32'h1);
		chk(aon, 32'h1);
		mode <= 2'h2;
		qw <= 1'b0;
	endtask : t_force

	// Continuous rounds; leaving the mode ends on a whole round
	task automatic t_cont();
		n_st = 0;
		mode <= 2'h3;
		repeat (100) @(posedge clk);
		#1 chk(aon, 32'h1);
		mode <= 2'h2;
		do
		begin
			@(posedge clk);
			#1;
		end
		while (busy);
		chk(n_st % 4, 32'h0);
		chk(n_st > 4, 32'h1);
	endtask : t_cont

	// Frozen core ignores a request write
	task automatic t_ce();
		mode <= 2'h0;
		ce <= 1'b0;
		@(posedge clk);
		os_wr <= 1'b1;
		@(posedge clk);
		os_wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(osr, 32'h0);
		ce <= 1'b1;
		mode <= 2'h2;
	endtask : t_ce

	initial
	begin
		{qw, dir, pol, hold, os_wr, frd, nrst, oe_q} = '0;
		{n_fail, n_compared, n_st, n_rise, n_rr, cyc} = '0;
		os_wd = 1'b1;
		ce = 1'b1;
		pin_drv = 1'b1;
		mode = 2'h2;
		func = 2'h0;
		fcnt = 2'h0;
		sel = 2'h2;
		lat = 8'h3;
		level = 26'h0;
		repeat (3) @(posedge lclk);
		@(posedge clk);
		nrst <= 1'b1;
		t_thr();
		t_reg(2'h1, 4);
		t_reg(2'h3, 1);
		t_reg(2'h2, 0);
		t_pin();
		t_force();
		t_cont();
		t_ce();
		end_of_test();
	end
endmodule : test_light_sensor_trigger_and_alert
`default_nettype wire
